// File: core/rxaf_pkg.sv
// Behaviour
// - DA first bit one means multicast
// - Perfect mode passes exact station matches
// - Inverse perfect passes non-matching destinations
// - Hash-only passes hash table hits
// - Inverse hash-only passes hash-only rejects
// - Hash perfect: unicast exact, multicast hash
// - Inverse hash perfect passes hash perfect rejects
// - Promiscuous passes every frame
// - All-frames only: unicast hash, multicast all
// - Unicast exact match, every multicast passes
// - Multicast hash hit, every unicast passes
// - Multicast exact match, every unicast passes
// - Optionally drop frames with own source
`default_nettype none

package rxaf_pkg;

  localparam int AW = 8;
  localparam int DW = 16;
  localparam int HASH_W = 6;
  localparam int DA_BYTES = 6;
  localparam int HDR_BYTES = 12;

  // Register offsets (word index on the plain register port)
  localparam logic [7:0] OFS_FILT = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h01;
  localparam logic [7:0] OFS_STA_LOW = 8'h02;
  localparam logic [7:0] OFS_STA_MID = 8'h03;
  localparam logic [7:0] OFS_STA_HIGH = 8'h04;
  localparam logic [7:0] OFS_HASH0 = 8'h05;
  localparam logic [7:0] OFS_HASH1 = 8'h06;
  localparam logic [7:0] OFS_HASH2 = 8'h07;
  localparam logic [7:0] OFS_HASH3 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h09;

  // Field positions in receive_filter_control
  localparam int FC_RX_EN = 0;
  localparam int FC_INV = 1;
  localparam int FC_ALL = 4;
  localparam int FC_UC_EN = 5;
  localparam int FC_MC_EN = 6;
  localparam int FC_MC_SEL = 8;
  localparam int FC_PHY_SEL = 11;
  // Field position in receive_control_second
  localparam int C2_SA_DROP = 0;
  // Group bit inside the first destination byte
  localparam int MC_BIT = 0;

  localparam logic [15:0] FILT_RST = 16'h0800;
  localparam logic [15:0] CTRL2_RST = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  // Mode codes, ordered {all, inverse, physical, multicast}
  localparam logic [3:0] MODE_PERFECT = 4'h3;
  localparam logic [3:0] MODE_INV_PERFECT = 4'h7;
  localparam logic [3:0] MODE_HASH = 4'h0;
  localparam logic [3:0] MODE_INV_HASH = 4'h4;
  localparam logic [3:0] MODE_HASH_PERF = 4'h2;
  localparam logic [3:0] MODE_INV_HASH_PERF = 4'h6;
  localparam logic [3:0] MODE_PROMISC = 4'hC;
  localparam logic [3:0] MODE_HASH_MC_ALL = 4'h8;
  localparam logic [3:0] MODE_PERF_MC_ALL = 4'hB;
  localparam logic [3:0] MODE_HASH_UC_ALL = 4'hA;
  localparam logic [3:0] MODE_PERF_UC_ALL = 4'h9;

  typedef logic [DW-1:0] rxaf_word_t;

  typedef struct packed {
    logic [7:0] data;
    logic sof;
    logic eof;
  } rxaf_beat_s;

endpackage

`default_nettype wire

// File: core/rxaf_top.sv
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rxaf_top (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [rxaf_pkg::AW-1:0] reg_addr_in,
  input wire rxaf_pkg::rxaf_word_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output rxaf_pkg::rxaf_word_t reg_rdata_out,
  input wire logic rx_valid_in,
  input wire rxaf_pkg::rxaf_beat_s rx_beat_in,
  input wire logic [rxaf_pkg::HASH_W-1:0] rx_hash_idx_in,
  output logic q_valid_out,
  output rxaf_pkg::rxaf_beat_s q_beat_out,
  output logic frame_pass_out,
  output logic frame_drop_out
);
  import rxaf_pkg::*;

  // Byte k of the station address, k counted over DA then SA
  // Wire order sends the high byte first, bits 47:40
  function automatic logic [7:0] sta_byte(input logic [47:0] sta,
                                          input logic [3:0] k);
    logic [2:0] j;
    logic [47:0] sh;
    j = (k >= 4'(DA_BYTES)) ? 3'(k - 4'(DA_BYTES)) : k[2:0];
    sh = sta >> (6'd40 - {j, 3'b000});
    return sh[7:0];
  endfunction

  // Mode table; unlisted codes reject so a bad setting fails safe
  function automatic logic mode_pass(input logic [3:0] mode,
                                     input logic mc,
                                     input logic pm,
                                     input logic hh);
    logic ok;
    ok = 1'b0;
    case (mode)
      MODE_PERFECT: ok = pm;
      MODE_INV_PERFECT: ok = !pm;
      MODE_HASH: ok = hh;
      MODE_INV_HASH: ok = !hh;
      MODE_HASH_PERF: ok = mc ? hh : pm;
      MODE_INV_HASH_PERF: ok = !(mc ? hh : pm);
      MODE_PROMISC: ok = 1'b1;
      MODE_HASH_MC_ALL: ok = mc ? 1'b1 : hh;
      MODE_PERF_MC_ALL: ok = mc ? 1'b1 : pm;
      MODE_HASH_UC_ALL: ok = mc ? hh : 1'b1;
      MODE_PERF_UC_ALL: ok = mc ? pm : 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Register file state
  rxaf_word_t filt_r, filt_nxt;
  rxaf_word_t ctrl2_r, ctrl2_nxt;
  logic [47:0] sta_r, sta_nxt;
  logic [63:0] hash_r, hash_nxt;
  rxaf_word_t rdata_r, rdata_nxt;
  // Status counters wrap at eight bits, software clears them
  logic [7:0] acc_cnt_r, acc_cnt_nxt;
  logic [7:0] rej_cnt_r, rej_cnt_nxt;

  // Frame header tracking state
  logic [3:0] cnt_r, cnt_nxt;
  // Match flags build up byte by byte against the station
  logic da_pm_r, da_pm_nxt;
  logic sa_pm_r, sa_pm_nxt;
  logic mc_r, mc_nxt;
  logic hdr_done_r, hdr_done_nxt;
  logic pass_r, pass_nxt;
  logic drain_r, drain_nxt;
  logic dec_pass, dec_drop;

  // Delay line holding the header until the verdict is known
  // Twelve deep so the verdict is ready before byte 0 leaves
  rxaf_beat_s line_r [HDR_BYTES];
  rxaf_beat_s line_nxt [HDR_BYTES];
  logic [HDR_BYTES-1:0] lv_r, lv_nxt;
  logic q_valid_nxt;
  rxaf_beat_s q_beat_nxt;
  // Verdict pulses go through flops before the pins
  logic fp_r, fd_r;

  // Header parse and verdict
  always_comb begin
    logic [3:0] idx;
    logic bm;
    logic hh;
    logic en;
    logic ok;
    idx = 4'h0;
    bm = 1'b0;
    hh = 1'b0;
    en = 1'b0;
    ok = 1'b0;
    cnt_nxt = cnt_r;
    da_pm_nxt = da_pm_r;
    sa_pm_nxt = sa_pm_r;
    mc_nxt = mc_r;
    hdr_done_nxt = hdr_done_r;
    pass_nxt = pass_r;
    drain_nxt = drain_r;
    dec_pass = 1'b0;
    dec_drop = 1'b0;
    if (rx_valid_in) begin
      idx = rx_beat_in.sof ? 4'h0 : cnt_r;
      bm = (rx_beat_in.data == sta_byte(sta_r, idx));
      if (idx == 4'h0) begin
        da_pm_nxt = bm;
        mc_nxt = rx_beat_in.data[MC_BIT];
        hdr_done_nxt = 1'b0;
        drain_nxt = 1'b0;
      end else if (idx < 4'(DA_BYTES)) begin
        da_pm_nxt = da_pm_r & bm;
      end
      // Flags freeze after the header so payload cannot disturb them
      if (idx == 4'(DA_BYTES)) begin
        sa_pm_nxt = bm;
      end else if (idx > 4'(DA_BYTES) && idx < 4'(HDR_BYTES)) begin
        sa_pm_nxt = sa_pm_r & bm;
      end
      if (idx < 4'(HDR_BYTES)) begin
        cnt_nxt = idx + 4'h1;
      end
      if (idx == 4'(HDR_BYTES - 1) && !hdr_done_r) begin
        // Bucket index is only promised on the last source byte
        hh = hash_r[rx_hash_idx_in];
        // Enables must be set by software or nothing passes
        en = filt_r[FC_RX_EN] &
             (mc_nxt ? filt_r[FC_MC_EN] : filt_r[FC_UC_EN]);
        ok = en & mode_pass({filt_r[FC_ALL], filt_r[FC_INV],
                             filt_r[FC_PHY_SEL], filt_r[FC_MC_SEL]},
                            mc_nxt, da_pm_nxt, hh);
        if (ctrl2_r[C2_SA_DROP] && sa_pm_nxt) begin
          ok = 1'b0;
        end
        pass_nxt = ok;
        hdr_done_nxt = 1'b1;
        dec_pass = ok;
        dec_drop = !ok;
      end
      // End of frame rewinds the count and starts the drain
      if (rx_beat_in.eof) begin
        cnt_nxt = 4'h0;
        drain_nxt = 1'b1;
        // Runt shorter than the header can never be judged
        if (!hdr_done_nxt) begin
          pass_nxt = 1'b0;
          dec_drop = 1'b1;
        end
      end
    end else if (drain_r && lv_r == '0) begin
      drain_nxt = 1'b0;
    end
  end

  // Delay line shifts on each beat, and freely only after end of frame
  always_comb begin
    logic shift;
    shift = rx_valid_in | (drain_r & (|lv_r));
    lv_nxt = lv_r;
    for (int i = 0; i < HDR_BYTES; i++) begin
      line_nxt[i] = line_r[i];
    end
    // Queue strobe is a one-cycle pulse per byte
    q_valid_nxt = 1'b0;
    q_beat_nxt = q_beat_out;
    if (shift) begin
      // Oldest byte leaves under the verdict of its own frame
      q_valid_nxt = lv_r[HDR_BYTES-1] & pass_r;
      if (lv_r[HDR_BYTES-1]) begin
        q_beat_nxt = line_r[HDR_BYTES-1];
      end
      for (int i = HDR_BYTES - 1; i > 0; i--) begin
        line_nxt[i] = line_r[i-1];
      end
      line_nxt[0] = rx_beat_in;
      lv_nxt = {lv_r[HDR_BYTES-2:0], rx_valid_in};
    end
  end

  // Register writes, read mux and verdict counters
  always_comb begin
    filt_nxt = filt_r;
    ctrl2_nxt = ctrl2_r;
    sta_nxt = sta_r;
    hash_nxt = hash_r;
    acc_cnt_nxt = acc_cnt_r + 8'(dec_pass);
    rej_cnt_nxt = rej_cnt_r + 8'(dec_drop);
    rdata_nxt = WORD_ZERO;
    // Unmapped writes fall through and change nothing
    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_FILT: filt_nxt = reg_wdata_in;
        OFS_CTRL2: ctrl2_nxt = reg_wdata_in;
        OFS_STA_LOW: sta_nxt[15:0] = reg_wdata_in;
        OFS_STA_MID: sta_nxt[31:16] = reg_wdata_in;
        OFS_STA_HIGH: sta_nxt[47:32] = reg_wdata_in;
        OFS_HASH0: hash_nxt[15:0] = reg_wdata_in;
        OFS_HASH1: hash_nxt[31:16] = reg_wdata_in;
        OFS_HASH2: hash_nxt[47:32] = reg_wdata_in;
        OFS_HASH3: hash_nxt[63:48] = reg_wdata_in;
        OFS_STATUS: begin
          // Clear still counts a verdict in the same cycle
          acc_cnt_nxt = 8'(dec_pass);
          rej_cnt_nxt = 8'(dec_drop);
        end
        default: ;
      endcase
    end
    // Read data stand one cycle, an idle port reads zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_FILT: rdata_nxt = filt_r;
        OFS_CTRL2: rdata_nxt = ctrl2_r;
        OFS_STA_LOW: rdata_nxt = sta_r[15:0];
        OFS_STA_MID: rdata_nxt = sta_r[31:16];
        OFS_STA_HIGH: rdata_nxt = sta_r[47:32];
        OFS_HASH0: rdata_nxt = hash_r[15:0];
        OFS_HASH1: rdata_nxt = hash_r[31:16];
        OFS_HASH2: rdata_nxt = hash_r[47:32];
        OFS_HASH3: rdata_nxt = hash_r[63:48];
        OFS_STATUS: rdata_nxt = {rej_cnt_r, acc_cnt_r};
        default: rdata_nxt = WORD_ZERO;
      endcase
    end
  end

  // Register file and status counters
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filt_r <= FILT_RST;
      ctrl2_r <= CTRL2_RST;
      sta_r <= '0;
      hash_r <= '0;
      rdata_r <= WORD_ZERO;
      acc_cnt_r <= 8'h00;
      rej_cnt_r <= 8'h00;
    end else begin
      filt_r <= filt_nxt;
      ctrl2_r <= ctrl2_nxt;
      sta_r <= sta_nxt;
      hash_r <= hash_nxt;
      rdata_r <= rdata_nxt;
      acc_cnt_r <= acc_cnt_nxt;
      rej_cnt_r <= rej_cnt_nxt;
    end
  end

  // Header tracking flags and verdict pulses
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= 4'h0;
      da_pm_r <= 1'b0;
      sa_pm_r <= 1'b0;
      mc_r <= 1'b0;
      hdr_done_r <= 1'b0;
      pass_r <= 1'b0;
      drain_r <= 1'b0;
      fp_r <= 1'b0;
      fd_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      da_pm_r <= da_pm_nxt;
      sa_pm_r <= sa_pm_nxt;
      mc_r <= mc_nxt;
      hdr_done_r <= hdr_done_nxt;
      pass_r <= pass_nxt;
      drain_r <= drain_nxt;
      fp_r <= dec_pass;
      fd_r <= dec_drop;
    end
  end

  // Delay line and queue outputs
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lv_r <= '0;
      for (int i = 0; i < HDR_BYTES; i++) begin
        line_r[i] <= '0;
      end
      q_valid_out <= 1'b0;
      q_beat_out <= '0;
    end else begin
      lv_r <= lv_nxt;
      for (int i = 0; i < HDR_BYTES; i++) begin
        line_r[i] <= line_nxt[i];
      end
      q_valid_out <= q_valid_nxt;
      q_beat_out <= q_beat_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_out = rdata_r;
  assign frame_pass_out = fp_r;
  assign frame_drop_out = fd_r;

endmodule

`default_nettype wire

// File: verification/rxaf_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rxaf_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [rxaf_pkg::AW-1:0] reg_addr_in,
  input wire rxaf_pkg::rxaf_word_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire rxaf_pkg::rxaf_word_t reg_rdata_out,
  input wire logic rx_valid_in,
  input wire rxaf_pkg::rxaf_beat_s rx_beat_in,
  input wire logic q_valid_out,
  input wire rxaf_pkg::rxaf_beat_s q_beat_out,
  input wire logic frame_pass_out,
  input wire logic frame_drop_out
);
  import rxaf_pkg::*;
  rxaf_word_t filt_r, filt_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic c2_r, c2_nxt, mc_r, mc_nxt, ok, vd;
  logic [3:0] md;
  // Shadow of filter setup, byte count and group flag
  always_comb begin
    filt_nxt = filt_r;
    c2_nxt = c2_r;
    cnt_nxt = cnt_r;
    mc_nxt = mc_r;
    if (reg_wr_in && reg_addr_in == OFS_FILT) filt_nxt = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == OFS_CTRL2) c2_nxt = reg_wdata_in[0];
    if (rx_valid_in) cnt_nxt = rx_beat_in.sof ? 8'h01 : cnt_r + 8'h01;
    if (rx_valid_in && rx_beat_in.sof) mc_nxt = rx_beat_in.data[MC_BIT];
  end
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filt_r <= FILT_RST;
      c2_r <= 1'b0;
      cnt_r <= 8'h00;
      mc_r <= 1'b0;
    end else begin
      filt_r <= filt_nxt;
      c2_r <= c2_nxt;
      cnt_r <= cnt_nxt;
      mc_r <= mc_nxt;
    end
  end
  // Own-source drop is folded into ok, so the pass checks apply only with it off
  assign vd = frame_pass_out | frame_drop_out;
  assign md = {filt_r[FC_ALL], filt_r[FC_INV], filt_r[FC_PHY_SEL],
    filt_r[FC_MC_SEL]};
  assign ok = filt_r[FC_RX_EN] & filt_r[FC_UC_EN] & filt_r[FC_MC_EN] & !c2_r;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  property p_excl; !(frame_pass_out && frame_drop_out); endproperty
  a_excl: assert property (p_excl) else $error("pass with drop");
  property p_time; frame_pass_out |-> $past(rx_valid_in) && cnt_r == 8'd12;
  endproperty
  a_time: assert property (p_time) else $error("pass off schedule");
  property p_off; vd && !filt_r[FC_RX_EN] |-> frame_drop_out; endproperty
  a_off: assert property (p_off) else $error("pass while off");
  property p_prom; vd && ok && md == MODE_PROMISC |-> frame_pass_out;
  endproperty
  a_prom: assert property (p_prom) else $error("promisc drop");
  property p_mca; vd && ok && mc_r && (md == MODE_HASH_MC_ALL ||
    md == MODE_PERF_MC_ALL) |-> frame_pass_out; endproperty
  a_mca: assert property (p_mca) else $error("group drop");
  property p_uca; vd && ok && !mc_r && (md == MODE_HASH_UC_ALL ||
    md == MODE_PERF_UC_ALL) |-> frame_pass_out; endproperty
  a_uca: assert property (p_uca) else $error("unicast drop");
  property p_drq; frame_drop_out |=> !q_valid_out [*4]; endproperty
  a_drq: assert property (p_drq) else $error("dropped frame queued");
  property p_pq; frame_pass_out && rx_valid_in |=> q_valid_out &&
    q_beat_out.sof; endproperty
  a_pq: assert property (p_pq) else $error("passed frame not queued");
  property p_rd0; !$past(reg_rd_in) |-> reg_rdata_out == WORD_ZERO;
  endproperty
  a_rd0: assert property (p_rd0) else $error("stray read data");
  c_pass: cover property (frame_pass_out);
  c_drop: cover property (frame_drop_out);
  c_eof: cover property (q_valid_out && q_beat_out.eof);
endmodule
bind rxaf_top rxaf_assertions u_chk (.clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .rx_valid_in(rx_valid_in), .rx_beat_in(rx_beat_in),
  .q_valid_out(q_valid_out), .q_beat_out(q_beat_out),
  .frame_pass_out(frame_pass_out), .frame_drop_out(frame_drop_out));
`default_nettype wire

// File: verification/rxaf_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module rxaf_mac_model (
  input wire logic clk_sys_in,
  output logic rx_valid_out,
  output rxaf_pkg::rxaf_beat_s rx_beat_out,
  output logic [rxaf_pkg::HASH_W-1:0] rx_hash_idx_out
);
  import rxaf_pkg::*;
  initial begin
    rx_valid_out = 1'b0;
    rx_beat_out = '0;
    rx_hash_idx_out = '0;
  end
  // Beats back to back; bucket is only true on the last source byte
  task automatic send(input logic [7:0] b[$], input logic [HASH_W-1:0] h);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge clk_sys_in);
      rx_valid_out <= 1'b1;
      rx_beat_out <= '{data: b[i], sof: i == 0, eof: i == b.size() - 1};
      rx_hash_idx_out <= (i == 11) ? h : ~h;
    end
    @(posedge clk_sys_in);
    rx_valid_out <= 1'b0;
    rx_beat_out.data <= ~rx_beat_out.data; // Idle line keeps no stale byte
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rxaf_pkg::*;
  logic clk_sys_in, rst_b_in, wr_s, rd_s, rx_v, q_v, pass, drop;
  logic rd_d = 1'b0;
  logic [AW-1:0] addr;
  logic [HASH_W-1:0] hix, h;
  rxaf_word_t wd, rdat;
  rxaf_beat_s rx_b, q_b;
  logic [47:0] sta, da;
  logic [63:0] ht;
  logic [3:0] m;
  logic [3:0] modes[11] = '{MODE_PERFECT, MODE_INV_PERFECT, MODE_HASH,
    MODE_INV_HASH, MODE_HASH_PERF, MODE_INV_HASH_PERF, MODE_PROMISC,
    MODE_HASH_MC_ALL, MODE_PERF_MC_ALL, MODE_HASH_UC_ALL, MODE_PERF_UC_ALL};
  logic [15:0] vq[$], rq[$], sq[$];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  rxaf_top DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_rdata_out(rdat), .rx_valid_in(rx_v),
    .rx_beat_in(rx_b), .rx_hash_idx_in(hix), .q_valid_out(q_v),
    .q_beat_out(q_b), .frame_pass_out(pass), .frame_drop_out(drop));
  rxaf_mac_model mac (.clk_sys_in(clk_sys_in), .rx_valid_out(rx_v),
    .rx_beat_out(rx_b), .rx_hash_idx_out(hix));
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    // Any verdict or read still owed counts against the run
    cmp(16'(vq.size() + sq.size() + rq.size()), 16'h0000);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Outputs settle after the rising edge, so sample on the falling one
  always @(negedge clk_sys_in) begin
    if (rd_d) cmp(rdat, rq.pop_front());
    rd_d = rd_s;
    if (pass | drop) cmp(16'({pass, drop}), vq.pop_front());
    if (q_v && q_b.sof) cmp(16'(q_b.data), sq.pop_front());
  end
  // Hang guard, well above the planned run length
  always @(negedge clk_sys_in) begin
    if (++cyc > 6000) begin
      fail_count++;
      complete_run();
    end
  end
  // One strobe cycle, read data noted for the monitor
  task automatic bus(input logic w, input logic [7:0] a, input rxaf_word_t d);
    if (!w) rq.push_back(d);
    @(posedge clk_sys_in);
    addr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge clk_sys_in);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  function automatic rxaf_word_t fv(input logic en);
    return {4'h0, m[1], 2'b00, m[0], 1'b0, en, en, m[3], 2'b00, m[2], en};
  endfunction
  function automatic logic [15:0] verdict(input logic mc, pm, hh);
    logic p;
    case (m)
      MODE_PERFECT: p = pm;
      MODE_INV_PERFECT: p = !pm;
      MODE_HASH: p = hh;
      MODE_INV_HASH: p = !hh;
      MODE_HASH_PERF: p = mc ? hh : pm;
      MODE_INV_HASH_PERF: p = !(mc ? hh : pm);
      MODE_PROMISC: p = 1'b1;
      MODE_HASH_MC_ALL: p = mc | hh;
      MODE_PERF_MC_ALL: p = mc | pm;
      MODE_HASH_UC_ALL: p = !mc | hh;
      MODE_PERF_UC_ALL: p = !mc | pm;
      default: p = 1'b0;
    endcase
    return p ? 16'h0002 : 16'h0001;
  endfunction
  // Long gap after each frame lets the delay line drain fully
  task automatic frame(input logic [47:0] sa, input int n,
                       input logic [15:0] v);
    logic [7:0] b[$];
    for (int i = 0; i < n; i++)
      b.push_back(i < 6 ? da[47-8*i -: 8] :
        (i < 12 ? sa[95-8*i -: 8] : 8'($urandom)));
    vq.push_back(v);
    if (v[1]) sq.push_back(16'(b[0]));
    mac.send(b, h);
    repeat (16) @(posedge clk_sys_in);
  endtask
  initial begin
    void'($urandom(32'h9619));
    rst_b_in = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = '0;
    wd = '0;
    repeat (4) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    bus(0, OFS_FILT, FILT_RST);
    bus(0, 8'hFF, WORD_ZERO);
    da = {$urandom, 16'h0};
    h = '0;
    frame(~da, 8, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      sta = {$urandom, 16'($urandom)};
      sta[40] = p[0];
      ht = {$urandom, $urandom};
      for (int k = 0; k < 3; k++)
        bus(1, OFS_STA_LOW + 8'(k), sta[16*k +: 16]);
      for (int k = 0; k < 4; k++)
        bus(1, OFS_HASH0 + 8'(k), ht[16*k +: 16]);
      foreach (modes[j]) begin
        m = modes[j];
        bus(1, OFS_FILT, fv(1'b1));
        for (int k = 0; k < 4; k++) begin
          h = 6'($urandom);
          da = k[0] ? sta ^ {47'h0, k[1]} : {$urandom, 16'($urandom)};
          if (!k[0]) da[40] = k[1];
          frame(~sta, 14, verdict(da[40], da == sta, ht[h]));
        end
      end
    end
    // Unlisted mode code must refuse every frame
    m = 4'hF;
    bus(1, OFS_FILT, fv(1'b1));
    bus(1, OFS_STATUS, WORD_ZERO);
    frame(~sta, 14, verdict(da[40], da == sta, ht[h]));
    bus(0, OFS_FILT, fv(1'b1));
    m = MODE_PROMISC;
    bus(1, OFS_FILT, fv(1'b1));
    bus(1, OFS_CTRL2, 16'h0001);
    frame(sta, 14, 16'h0001);
    frame(~sta, 14, 16'h0002);
    bus(1, OFS_FILT, fv(1'b0));
    frame(~sta, 14, 16'h0001);
    // Three drops and one pass since the clear
    bus(0, OFS_STATUS, 16'h0301);
    repeat (2) @(posedge clk_sys_in);
    complete_run();
  end
endmodule
`default_nettype wire
